// ---- logic/tmq_pkg.sv ----
// Package for the temperature alert qualifier: register map, fields, resets, timing, carriers
package tmq_pkg;

  // Register addresses on the device register port
  localparam logic [7:0] TMQ_ADDR_MASK = 8'h1f;
  localparam logic [7:0] TMQ_ADDR_CONSEC = 8'h22;
  localparam logic [7:0] TMQ_ADDR_HIGH = 8'h35;

  // Channel indices, equal to their bit positions in mask and status registers
  localparam int TMQ_NCH = 2;
  localparam int TMQ_CH_INT = 0;
  localparam int TMQ_CH_EXT = 1;

  // Consecutive count register layout
  localparam int TMQ_TO_EN_BIT = 7;
  localparam int TMQ_SD_LSB = 4;
  localparam int TMQ_AL_LSB = 1;
  localparam int TMQ_SEL_W = 3;

  // Power-on values of the count register fields
  localparam logic TMQ_TO_EN_RST = 1'b0;
  localparam logic [2:0] TMQ_SD_SEL_RST = 3'h7;
  localparam logic [2:0] TMQ_AL_SEL_RST = 3'h0;

  // Counters saturate at the largest programmable count
  localparam logic [2:0] TMQ_CNT_MAX = 3'h4;
  localparam logic [2:0] TMQ_CNT_ONE = 3'h1;

  // Bus clock low timeout
  localparam int TMQ_TIMEOUT_MS = 30;
  localparam int TMQ_MCLK_KHZ = 100000;
  localparam int TMQ_TIMEOUT_CYC = TMQ_TIMEOUT_MS * TMQ_MCLK_KHZ;

  // Per-channel comparison results of one finished conversion
  typedef struct packed {
    logic high;
    logic low;
    logic fault;
    logic crit;
    logic crit_clr;
    logic high_clr;
  } tmq_meas_s;

  // Hardware shutdown limit comparison of the external channel
  typedef struct packed {
    logic hw_over;
    logic hw_clr;
  } tmq_hw_s;

  // Register request from the bus protocol engine, link clock
  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmq_req_s;

  // Register answer to the bus protocol engine, link clock
  typedef struct packed {
    logic ack;
    logic busy;
    logic [7:0] rdata;
  } tmq_rsp_s;

  // Main clock state
  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic ack_tgl;
    logic [7:0] rdata;
    logic [1:0] mask;
    logic to_en;
    logic [2:0] sd_sel;
    logic [2:0] al_sel;
    logic [1:0] hi;
    logic [1:0][2:0] al_cnt;
    logic [1:0] al_pend;
    logic [1:0] cmp_act;
    logic [1:0][2:0] sd_cnt;
    logic [1:0] crit_act;
    logic hw_act;
    logic [1:0] crit_flag;
    logic alert;
    logic shdn;
    logic smclk_s1;
    logic smclk_s2;
    logic [31:0] to_cnt;
    logic to_fired;
    logic to_pulse;
  } tmq_core_s;

  // Link clock state
  typedef struct packed {
    logic req_tgl;
    logic busy;
    logic ack_s1;
    logic ack_s2;
    logic ack_s3;
    tmq_req_s hold;
    tmq_rsp_s rsp;
  } tmq_link_s;

endpackage

// ---- logic/tmq_alert_qualifier.sv ----
// Alert and shutdown qualification with read-clear high flags and bus timeout
//
// Function
// - Masked channel never raises alert, ext faults too
// - Mask never affects the shutdown output
// - Internal mask gates only internal limit alerts
// - Interrupt mode alert counter counts consecutive high, low, ext fault
// - Clean conversion clears the channel alert counter unless a comparator alert still holds
// - Interrupt mode: set flags, alert, clear counter
// - Comparator mode counts only high limit exceedances
// - Comparator alert holds until below high hysteresis
// - Timeout enabled: reset protocol after 30 ms low
// - Timeout disabled: clock low never resets protocol
// - Shutdown counter counts critical or hardware exceedances
// - Shutdown counter resets below limit before asserting
// - Count reached and linked drives shutdown low
// - Asserted shutdown counter clears only below hysteresis
// - Count codes 000,001,011,111 mean 1 to 4
// - Alert count field same decode, default one
// - Own counters per channel, shared threshold
// - Channel above high limit at its alert count sets its high flag
// - Reading high flags clears them and summary
// - Alert needs count met and a high flag
// - High flags sticky, comparator mode follows condition
// - Unimplemented register bits read as zero
// - Critical counter drives shutdown only when linked
// - Hardware shutdown holds until ten degrees below
`timescale 1ns/1ns
module tmq_alert_qualifier
  import tmq_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TMQ_TIMEOUT_CYC
) (
  // Main clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Register port from the bus protocol engine
  input wire logic lclk,
  input wire tmq_req_s reg_req,
  output tmq_rsp_s reg_rsp,
  // Bus clock pin, for the low timeout
  input wire logic smclk_pin,
  output logic smbus_timeout_reset,
  // Conversion results, main clock
  input wire logic [1:0] conv_done,
  input wire tmq_meas_s [1:0] meas,
  input wire tmq_hw_s hw_meas,
  // Configuration held elsewhere
  input wire logic alert_comp_mode,
  input wire logic ext_shutdown_link,
  input wire logic int_shutdown_link,
  // Outputs
  output logic alert_n,
  output logic system_shutdown_out_n,
  output logic status_high,
  output logic ext_critical_flag,
  output logic int_critical_flag
);

  // Counter is 32 bits wide and must be able to reach the limit
  if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 32'h7fff_ffff) begin : g_bad_timeout
    $error("TIMEOUT_CYCLES out of range");
  end

  tmq_core_s c_q;
  tmq_core_s c_d;
  tmq_link_s l_q;
  tmq_link_s l_d;
  logic acc;
  logic rd_hi;
  logic [1:0] hi_set;
  logic [1:0] link;
  logic [2:0] al_thr;
  logic [2:0] sd_thr;
  logic [2:0] inc;

  // Code to count: each set bit adds one measurement
  function automatic logic [2:0] count_of(input logic [2:0] code);
    count_of = {2'h0, code[0]} + {2'h0, code[1]} + {2'h0, code[2]} + TMQ_CNT_ONE;
  endfunction

  // One step of a saturating counter
  function automatic logic [2:0] step(input logic [2:0] cnt);
    step = (cnt >= TMQ_CNT_MAX) ? cnt : cnt + TMQ_CNT_ONE;
  endfunction

  assign link = {ext_shutdown_link, int_shutdown_link};
  assign al_thr = count_of(c_q.al_sel);
  assign sd_thr = count_of(c_q.sd_sel);

  // Link side: take a request, toggle it across, wait for the answer toggle
  always_comb begin
    l_d = l_q;
    l_d.rsp.ack = 1'b0;
    l_d.ack_s1 = c_q.ack_tgl;
    l_d.ack_s2 = l_q.ack_s1;
    l_d.ack_s3 = l_q.ack_s2;
    if (l_q.ack_s2 ^ l_q.ack_s3) begin
      l_d.busy = 1'b0;
      l_d.rsp.ack = 1'b1;
      l_d.rsp.rdata = c_q.rdata;
    end
    // Held words stay still until the answer, so the main side may read them
    if (reg_req.req && !l_q.busy) begin
      l_d.hold = reg_req;
      l_d.req_tgl = ~l_q.req_tgl;
      l_d.busy = 1'b1;
    end
    l_d.rsp.busy = l_d.busy;
  end

  always_ff @(posedge lclk or negedge arst_n) begin
    if (!arst_n) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  assign reg_rsp = l_q.rsp;

  // Main side: register access, channel qualification, timeout
  always_comb begin
    c_d = c_q;
    inc = 3'h0;
    hi_set = 2'h0;
    c_d.req_s1 = l_q.req_tgl;
    c_d.req_s2 = c_q.req_s1;
    c_d.req_s3 = c_q.req_s2;
    acc = c_q.req_s2 ^ c_q.req_s3;
    rd_hi = acc && !l_q.hold.we && (l_q.hold.addr == TMQ_ADDR_HIGH);
    c_d.to_pulse = 1'b0;

    // Register access; unmapped addresses read zero and ignore writes
    if (acc) begin
      c_d.ack_tgl = ~c_q.ack_tgl;
      c_d.rdata = 8'h00;
      unique case (l_q.hold.addr)
        TMQ_ADDR_MASK: begin
          c_d.rdata = {6'h00, c_q.mask};
          if (l_q.hold.we) begin
            c_d.mask = l_q.hold.wdata[TMQ_CH_EXT:TMQ_CH_INT];
          end
        end
        TMQ_ADDR_CONSEC: begin
          c_d.rdata = {c_q.to_en, c_q.sd_sel, c_q.al_sel, 1'b0};
          if (l_q.hold.we) begin
            c_d.to_en = l_q.hold.wdata[TMQ_TO_EN_BIT];
            c_d.sd_sel = l_q.hold.wdata[TMQ_SD_LSB +: TMQ_SEL_W];
            c_d.al_sel = l_q.hold.wdata[TMQ_AL_LSB +: TMQ_SEL_W];
          end
        end
        TMQ_ADDR_HIGH: begin
          c_d.rdata = {6'h00, c_q.hi};
        end
        default: begin
          c_d.rdata = 8'h00;
        end
      endcase
    end

    // Each channel keeps its own counters against the shared thresholds
    for (int c = 0; c < TMQ_NCH; c++) begin
      if (conv_done[c]) begin
        // Alert path
        if (alert_comp_mode) begin
          if (meas[c].high) begin
            inc = step(c_q.al_cnt[c]);
            c_d.al_cnt[c] = inc;
            if (inc >= al_thr) begin
              c_d.cmp_act[c] = 1'b1;
            end
          end else if (!(c_q.cmp_act[c] && !meas[c].high_clr)) begin
            c_d.al_cnt[c] = 3'h0;
            c_d.cmp_act[c] = 1'b0;
          end
        end else begin
          // Internal channel has no fault source
          if (meas[c].high || meas[c].low || (c == TMQ_CH_EXT && meas[c].fault)) begin
            inc = step(c_q.al_cnt[c]);
            if (inc >= al_thr) begin
              hi_set[c] = meas[c].high;
              c_d.al_cnt[c] = 3'h0;
              if (!c_q.mask[c] && meas[c].high) begin
                c_d.al_pend[c] = 1'b1;
              end
            end else begin
              c_d.al_cnt[c] = inc;
            end
          end else begin
            c_d.al_cnt[c] = 3'h0;
          end
        end

        // Critical status follows the limit with hysteresis, linked or not
        if (meas[c].crit) begin
          c_d.crit_flag[c] = 1'b1;
        end else if (meas[c].crit_clr) begin
          c_d.crit_flag[c] = 1'b0;
        end

        // Shutdown path
        if (meas[c].crit || (c == TMQ_CH_EXT && hw_meas.hw_over)) begin
          inc = step(c_q.sd_cnt[c]);
          c_d.sd_cnt[c] = inc;
          if (inc >= sd_thr) begin
            if (meas[c].crit) begin
              c_d.crit_act[c] = 1'b1;
            end
            if (c == TMQ_CH_EXT && hw_meas.hw_over) begin
              c_d.hw_act = 1'b1;
            end
          end
        end else begin
          if (c_q.crit_act[c] && meas[c].crit_clr) begin
            c_d.crit_act[c] = 1'b0;
          end
          if (c == TMQ_CH_EXT && c_q.hw_act && hw_meas.hw_clr) begin
            c_d.hw_act = 1'b0;
          end
          // Hold while any assertion of this channel still stands
          if (!(c_d.crit_act[c] || (c == TMQ_CH_EXT && c_d.hw_act))) begin
            c_d.sd_cnt[c] = 3'h0;
          end
        end
      end
    end

    // High flags: sticky with read clear, set wins; comparator mode follows
    if (alert_comp_mode) begin
      c_d.hi = c_d.cmp_act;
      c_d.al_pend = 2'h0;
    end else begin
      c_d.hi = (c_q.hi & ~{2{rd_hi}}) | hi_set;
      c_d.al_pend = (c_d.al_pend & ~{2{rd_hi}}) | (hi_set & ~c_q.mask);
    end

    // Alert needs a met count, an unmasked channel and a high flag
    if (alert_comp_mode) begin
      c_d.alert = |(c_d.cmp_act & ~c_d.mask);
    end else begin
      c_d.alert = |(c_d.al_pend & c_d.hi & ~c_d.mask);
    end

    // Mask is deliberately absent here
    c_d.shdn = |(c_d.crit_act & link) | c_d.hw_act;

    // Clock low timeout, one pulse per low period
    c_d.smclk_s1 = smclk_pin;
    c_d.smclk_s2 = c_q.smclk_s1;
    if (!c_q.to_en || c_q.smclk_s2) begin
      c_d.to_cnt = 32'h0;
      c_d.to_fired = 1'b0;
    end else if (!c_q.to_fired) begin
      c_d.to_cnt = c_q.to_cnt + 32'h1;
      if (c_d.to_cnt == 32'(TIMEOUT_CYCLES)) begin
        c_d.to_pulse = 1'b1;
        c_d.to_fired = 1'b1;
      end
    end
  end

  // Power-on clears everything but the default count codes and the bus clock synchronizer, which starts high
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      c_q <= '0;
      c_q.to_en <= TMQ_TO_EN_RST;
      c_q.sd_sel <= TMQ_SD_SEL_RST;
      c_q.al_sel <= TMQ_AL_SEL_RST;
      c_q.smclk_s1 <= 1'b1;
      c_q.smclk_s2 <= 1'b1;
    end else begin
      c_q <= c_d;
    end
  end

  assign alert_n = ~c_q.alert;
  assign system_shutdown_out_n = ~c_q.shdn;
  assign status_high = |c_q.hi;
  assign ext_critical_flag = c_q.crit_flag[TMQ_CH_EXT];
  assign int_critical_flag = c_q.crit_flag[TMQ_CH_INT];
  assign smbus_timeout_reset = c_q.to_pulse;

  // Alert only from an unmasked channel
  alert_mask_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !alert_n |-> |((c_q.al_pend | c_q.cmp_act) & ~c_q.mask))
    else $error("alert from masked channel");

  // Hardware shutdown ignores mask and links
  shdn_hw_a: assert property (@(posedge mclk) disable iff (!arst_n)
    c_q.hw_act |-> !system_shutdown_out_n)
    else $error("hardware shutdown not driven");

  // Clean conversion clears alert counter
  alert_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
    conv_done[TMQ_CH_INT] && !alert_comp_mode && !meas[TMQ_CH_INT].high && !meas[TMQ_CH_INT].low
    |=> c_q.al_cnt[TMQ_CH_INT] == 3'h0)
    else $error("alert counter not cleared");

  // Interrupt mode count reached sets flag and clears counter
  int_reach_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (!alert_comp_mode && conv_done[TMQ_CH_EXT] && meas[TMQ_CH_EXT].high
     && step(c_q.al_cnt[TMQ_CH_EXT]) >= al_thr) ##1 !alert_comp_mode
    |-> c_q.hi[TMQ_CH_EXT] && c_q.al_cnt[TMQ_CH_EXT] == 3'h0)
    else $error("interrupt threshold not handled");

  // Comparator reach keeps the count
  cmp_reach_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (alert_comp_mode && conv_done[TMQ_CH_EXT] && meas[TMQ_CH_EXT].high
     && step(c_q.al_cnt[TMQ_CH_EXT]) >= al_thr)
    |=> c_q.cmp_act[TMQ_CH_EXT] && c_q.al_cnt[TMQ_CH_EXT] != 3'h0)
    else $error("comparator threshold not held");

  // Timeout pulse at the exact count
  timeout_fire_a: assert property (@(posedge mclk) disable iff (!arst_n)
    smbus_timeout_reset |-> c_q.to_cnt == 32'(TIMEOUT_CYCLES) && $past(c_q.to_en) && !$past(c_q.smclk_s2))
    else $error("timeout pulse at wrong time");

  // No timeout while disabled
  timeout_off_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !$past(c_q.to_en) |-> !smbus_timeout_reset)
    else $error("timeout while disabled");

  // Reading high flags clears them
  hi_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
    rd_hi && !alert_comp_mode && hi_set == 2'h0 |=> c_q.hi == 2'h0 && !status_high)
    else $error("high flags survive read");

  // Shutdown from a critical counter only when linked
  shdn_link_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !system_shutdown_out_n |-> c_q.hw_act || |(c_q.crit_act & $past(link)))
    else $error("unlinked channel drove shutdown");

  // Unimplemented bits read zero
  mask_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
    acc && l_q.hold.addr == TMQ_ADDR_MASK |=> c_q.rdata[7:2] == 6'h00)
    else $error("reserved mask bits nonzero");

  // Below the limit before assertion, the shutdown counter restarts
  sd_reset_a: assert property (@(posedge mclk) disable iff (!arst_n)
    conv_done[TMQ_CH_INT] && !meas[TMQ_CH_INT].crit && !c_q.crit_act[TMQ_CH_INT]
    |=> c_q.sd_cnt[TMQ_CH_INT] == 3'h0)
    else $error("shutdown counter not reset");

  // Asserted shutdown keeps its count inside the hysteresis band
  shdn_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    conv_done[TMQ_CH_INT] && c_q.crit_act[TMQ_CH_INT] && !meas[TMQ_CH_INT].crit && !meas[TMQ_CH_INT].crit_clr
    |=> c_q.crit_act[TMQ_CH_INT] && c_q.sd_cnt[TMQ_CH_INT] == $past(c_q.sd_cnt[TMQ_CH_INT]))
    else $error("shutdown released inside hysteresis");

  // Comparator mode drops low and fault results
  cmp_low_a: assert property (@(posedge mclk) disable iff (!arst_n)
    conv_done[TMQ_CH_EXT] && alert_comp_mode && !meas[TMQ_CH_EXT].high && !c_q.cmp_act[TMQ_CH_EXT]
    |=> c_q.al_cnt[TMQ_CH_EXT] == 3'h0)
    else $error("comparator counted a non-high result");

  // Hardware shutdown holds until its own clear input
  hw_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    conv_done[TMQ_CH_EXT] && c_q.hw_act && !hw_meas.hw_clr |=> c_q.hw_act)
    else $error("hardware shutdown released early");

  // Listed shutdown codes give their counts
  sd_decode_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (c_q.sd_sel == 3'h3 |-> sd_thr == 3'h3) and (c_q.sd_sel == 3'h7 |-> sd_thr == 3'h4))
    else $error("shutdown count decode wrong");

  // Alert codes decode the same way
  al_decode_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (c_q.al_sel == 3'h0 |-> al_thr == 3'h1) and (c_q.al_sel == 3'h1 |-> al_thr == 3'h2))
    else $error("alert count decode wrong");

  // Counters hold between conversions of their channel
  cnt_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !conv_done[TMQ_CH_EXT] |=> $stable(c_q.al_cnt[TMQ_CH_EXT]) && $stable(c_q.sd_cnt[TMQ_CH_EXT]))
    else $error("counter moved without conversion");

endmodule

// ---- test/tmq_link_host.sv ----
// Bus protocol engine model driving the register port on the link clock
`timescale 1ns/1ns
module tmq_link_host
  import tmq_pkg::*;
(
  // Link clock
  input wire logic lclk,
  // Register port
  output tmq_req_s reg_req,
  input wire tmq_rsp_s reg_rsp
);
  // Idle until the first access
  initial reg_req = '0;

  // One access: raise after an edge, drop after the take, bounded wait for ack
  task automatic access(input logic we, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic ok);
    int n;
    ok = 1'b0;
    rdata = 8'h00;
    @(posedge lclk);
    reg_req <= '{req: 1'b1, we: we, addr: addr, wdata: wdata};
    @(posedge lclk);
    // Released lines carry the inverse, never a stale copy
    reg_req <= '{req: 1'b0, we: ~we, addr: ~addr, wdata: ~wdata};
    for (n = 0; n < 14 && !ok; n++) begin
      // Ack stands a whole link cycle, so the falling edge sees it settled
      @(negedge lclk);
      if (reg_rsp.ack === 1'b1) begin
        ok = 1'b1;
        rdata = reg_rsp.rdata;
      end
    end
  endtask
endmodule

// ---- test/tmq_alert_qualifier_tb.sv ----
// Self-checking bench for the temperature alert qualifier
`timescale 1ns/1ns
module tmq_alert_qualifier_tb
  import tmq_pkg::*;
;
  // Short timeout keeps the run brief; result codes high,low,fault,crit,crit_clr,high_clr
  localparam int TO_CYC = 20;
  localparam logic [5:0] M_HI = 6'h20;
  localparam logic [5:0] M_LO = 6'h10;
  localparam logic [5:0] M_FT = 6'h08;
  localparam logic [5:0] M_CR = 6'h04;
  localparam logic [5:0] M_OK = 6'h03;
  localparam logic [5:0] M_MID = 6'h00;
  logic mclk, lclk, arst_n, smclk_pin, to_pulse, comp, ext_link, int_link;
  logic alert_n, shdn_n, status_high, ext_crit, int_crit;
  logic [1:0] conv_done;
  tmq_meas_s [1:0] meas;
  tmq_hw_s hw_meas;
  tmq_req_s reg_req;
  tmq_rsp_s reg_rsp;
  int errors, samples_checked, p0;
  int pulses = 0;
  logic [7:0] rd;
  logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h3, 3'h7};

  // Main clock 100 MHz, link clock 32 ns with its own phase
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #16 lclk = ~lclk;
  end

  // Device and its bus protocol engine
  tmq_alert_qualifier #(.TIMEOUT_CYCLES(TO_CYC)) u_tmq_alert_qualifier (
    .mclk(mclk), .arst_n(arst_n), .lclk(lclk), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .smclk_pin(smclk_pin), .smbus_timeout_reset(to_pulse), .conv_done(conv_done), .meas(meas),
    .hw_meas(hw_meas), .alert_comp_mode(comp), .ext_shutdown_link(ext_link),
    .int_shutdown_link(int_link), .alert_n(alert_n), .system_shutdown_out_n(shdn_n),
    .status_high(status_high), .ext_critical_flag(ext_crit), .int_critical_flag(int_crit));
  tmq_link_host u_tmq_link_host (.lclk(lclk), .reg_req(reg_req), .reg_rsp(reg_rsp));

  // Timeout pulses counted as they come; they last one cycle
  always @(posedge mclk) begin
    if (to_pulse === 1'b1) pulses <= pulses + 1;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic lvl(input string name, input logic seen, input logic exp);
    check(name, {7'h00, seen}, {7'h00, exp});
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A lost ack means the port hung, so stop rather than read junk
  task automatic rw(input logic we, input logic [7:0] addr, input logic [7:0] wd);
    logic ok;
    u_tmq_link_host.access(we, addr, wd, rd, ok);
    if (ok !== 1'b1) begin
      errors++;
      $display("Error ack expected 1 seen 0");
      end_of_test();
    end
  endtask

  // One finished conversion on channel ch (1 ext, 0 int)
  task automatic conv(input logic ch, input logic [5:0] m, input logic [1:0] hw);
    @(posedge mclk);
    conv_done <= {ch, ~ch};
    meas <= ch ? {tmq_meas_s'(m), meas[0]} : {meas[1], tmq_meas_s'(m)};
    hw_meas <= tmq_hw_s'(hw);
    @(posedge mclk);
    conv_done <= 2'b00;
    @(negedge mclk);
  endtask

  // Bus clock held low for three times the timeout
  task automatic bus_low(input logic [7:0] exp);
    p0 = pulses;
    @(posedge mclk);
    smclk_pin <= 1'b0;
    repeat (3 * TO_CYC) @(posedge mclk);
    smclk_pin <= 1'b1;
    repeat (4) @(negedge mclk);
    check("timeout_pulses", 8'(pulses - p0), exp);
  endtask

  // Hang guard
  initial begin
    #1000000;
    errors++;
    $display("Error watchdog expected done seen hang");
    end_of_test();
  end

  // Main sequence
  initial begin
    arst_n = 1'b0;
    smclk_pin = 1'b1;
    conv_done = 2'b00;
    meas = '0;
    hw_meas = '0;
    comp = 1'b0;
    ext_link = 1'b0;
    int_link = 1'b0;
    errors = 0;
    samples_checked = 0;
    rd = 8'h00;
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    // Power-on contents, reserved bits and an unmapped place
    rw(1'b0, TMQ_ADDR_MASK, 8'h00);
    check("mask_por", rd, 8'h00);
    rw(1'b0, TMQ_ADDR_CONSEC, 8'h00);
    check("consec_por", rd, 8'h70);
    rw(1'b0, TMQ_ADDR_HIGH, 8'h00);
    check("high_por", rd, 8'h00);
    lvl("shdn_por", shdn_n, 1'b1);
    lvl("alert_por", alert_n, 1'b1);
    lvl("stat_por", status_high, 1'b0);
    check("crit_por", {6'h00, ext_crit, int_crit}, 8'h00);
    rw(1'b1, TMQ_ADDR_MASK, 8'hff);
    rw(1'b0, TMQ_ADDR_MASK, 8'h00);
    check("mask_rsv", rd, 8'h03);
    rw(1'b1, TMQ_ADDR_CONSEC, 8'h7f);
    rw(1'b0, TMQ_ADDR_CONSEC, 8'h00);
    check("consec_rsv", rd, 8'h7e);
    rw(1'b1, 8'h40, 8'hff);
    rw(1'b0, 8'h40, 8'h00);
    check("unmapped", rd, 8'h00);
    // Alert count decode, interrupt mode, external channel
    rw(1'b1, TMQ_ADDR_MASK, 8'h00);
    foreach (codes[i]) begin
      rw(1'b1, TMQ_ADDR_CONSEC, 8'h70 | {4'h0, codes[i], 1'b0});
      repeat (i) conv(1'b1, M_HI, 2'b00);
      conv(1'b1, M_OK, 2'b00);
      repeat (i) conv(1'b1, M_HI, 2'b00);
      conv(1'b0, M_OK, 2'b00);
      lvl("alert_early", alert_n, 1'b1);
      conv(1'b1, M_HI, 2'b00);
      lvl("alert_cnt", alert_n, 1'b0);
      lvl("summary", status_high, 1'b1);
      rw(1'b0, TMQ_ADDR_HIGH, 8'h00);
      check("high_rd", rd, 8'h02);
      lvl("alert_clr", alert_n, 1'b1);
      lvl("summary_clr", status_high, 1'b0);
      if (i > 0) begin
        conv(1'b1, M_HI, 2'b00);
        lvl("cnt_cleared", alert_n, 1'b1);
        conv(1'b1, M_OK, 2'b00);
      end
    end
    // Shutdown count decode on the masked internal channel
    rw(1'b1, TMQ_ADDR_MASK, 8'h03);
    @(posedge mclk);
    int_link <= 1'b1;
    foreach (codes[i]) begin
      rw(1'b1, TMQ_ADDR_CONSEC, {1'b0, codes[i], 4'h0});
      repeat (i) conv(1'b0, M_CR, 2'b00);
      conv(1'b0, M_MID, 2'b00);
      repeat (i) conv(1'b0, M_CR, 2'b00);
      lvl("shdn_early", shdn_n, 1'b1);
      conv(1'b0, M_CR, 2'b00);
      lvl("shdn_cnt", shdn_n, 1'b0);
      lvl("int_crit", int_crit, 1'b1);
      conv(1'b0, M_MID, 2'b00);
      lvl("shdn_hold", shdn_n, 1'b0);
      conv(1'b0, M_OK, 2'b00);
      lvl("shdn_rel", shdn_n, 1'b1);
    end
    // Unlinked channel only flags, code 000
    @(posedge mclk);
    int_link <= 1'b0;
    rw(1'b1, TMQ_ADDR_CONSEC, 8'h00);
    conv(1'b0, M_CR, 2'b00);
    lvl("unlinked", shdn_n, 1'b1);
    lvl("unlinked_flag", int_crit, 1'b1);
    conv(1'b0, M_OK, 2'b00);
    // Hardware limit asserts without a link, default count of four
    rw(1'b1, TMQ_ADDR_CONSEC, 8'h70);
    repeat (3) conv(1'b1, M_MID, 2'b10);
    lvl("hw_early", shdn_n, 1'b1);
    conv(1'b1, M_MID, 2'b10);
    lvl("hw_shdn", shdn_n, 1'b0);
    conv(1'b1, M_MID, 2'b00);
    lvl("hw_hold", shdn_n, 1'b0);
    conv(1'b1, M_OK, 2'b01);
    lvl("hw_rel", shdn_n, 1'b1);
    // Linked external channel, still masked, drives shutdown from its critical counter
    @(posedge mclk);
    ext_link <= 1'b1;
    rw(1'b1, TMQ_ADDR_CONSEC, 8'h00);
    conv(1'b1, M_CR, 2'b00);
    lvl("ext_shdn", shdn_n, 1'b0);
    lvl("ext_crit", ext_crit, 1'b1);
    conv(1'b1, M_OK, 2'b00);
    lvl("ext_rel", shdn_n, 1'b1);
    lvl("ext_crit_clr", ext_crit, 1'b0);
    @(posedge mclk);
    ext_link <= 1'b0;
    // External mask covers faults and limits, internal still alerts
    rw(1'b1, TMQ_ADDR_MASK, 8'h02);
    conv(1'b1, M_FT, 2'b00);
    lvl("mask_fault", alert_n, 1'b1);
    conv(1'b1, M_HI, 2'b00);
    lvl("mask_high", alert_n, 1'b1);
    conv(1'b0, M_HI, 2'b00);
    lvl("int_alert", alert_n, 1'b0);
    rw(1'b0, TMQ_ADDR_HIGH, 8'h00);
    check("both_high", rd, 8'h03);
    lvl("int_alert_clr", alert_n, 1'b1);
    // Count of two: int fault is ignored, ext low and fault count toward it
    rw(1'b1, TMQ_ADDR_MASK, 8'h00);
    rw(1'b1, TMQ_ADDR_CONSEC, 8'h72);
    conv(1'b0, M_FT, 2'b00);
    conv(1'b0, M_HI, 2'b00);
    lvl("int_fault_ign", alert_n, 1'b1);
    conv(1'b0, M_OK, 2'b00);
    conv(1'b1, M_LO, 2'b00);
    lvl("low_one", alert_n, 1'b1);
    conv(1'b1, M_HI, 2'b00);
    lvl("low_counts", alert_n, 1'b0);
    rw(1'b0, TMQ_ADDR_HIGH, 8'h00);
    check("low_high_rd", rd, 8'h02);
    conv(1'b1, M_FT, 2'b00);
    conv(1'b1, M_HI, 2'b00);
    lvl("fault_counts", alert_n, 1'b0);
    rw(1'b0, TMQ_ADDR_HIGH, 8'h00);
    rw(1'b1, TMQ_ADDR_CONSEC, 8'h70);
    // Comparator mode: high only, hysteresis hold, flags follow condition
    rw(1'b1, TMQ_ADDR_MASK, 8'h00);
    @(posedge mclk);
    comp <= 1'b1;
    conv(1'b1, M_LO, 2'b00);
    lvl("cmp_low", alert_n, 1'b1);
    conv(1'b1, M_FT, 2'b00);
    lvl("cmp_fault", alert_n, 1'b1);
    conv(1'b1, M_HI, 2'b00);
    lvl("cmp_high", alert_n, 1'b0);
    conv(1'b1, M_MID, 2'b00);
    lvl("cmp_hold", alert_n, 1'b0);
    rw(1'b0, TMQ_ADDR_HIGH, 8'h00);
    check("cmp_no_clr", rd, 8'h02);
    conv(1'b1, M_OK, 2'b00);
    lvl("cmp_rel", alert_n, 1'b1);
    lvl("cmp_follow", status_high, 1'b0);
    // Bus clock low timeout, disabled then enabled
    @(posedge mclk);
    comp <= 1'b0;
    bus_low(8'h00);
    rw(1'b1, TMQ_ADDR_CONSEC, 8'hf0);
    bus_low(8'h01);
    end_of_test();
  end
endmodule
